/* File: asrc_host_model.sv */
// host model driving the clock, start, serial clock and reset pins
`timescale 1ns/1ps
module asrc_host_model (
  output logic convert_request_n_clk,
  output logic serial_clk,
  output logic convert_request_n,
  output logic cal_reset_n,
  input wire logic done_n,
  input wire logic serial_out
);
  logic s;

  // idle levels; the clock stands high between bursts
  // serial clock grounded in mode 1
  initial begin
    convert_request_n_clk = 1'b1;
    serial_clk = 1'b0;
    convert_request_n = 1'b1;
    cal_reset_n = 1'b1;
  end

  // ****************************************************************
  // clock tasks
  // ****************************************************************
  // capture just before the next fall
  // full periods only, never a short pulse
  task automatic pulse(output logic smp);
    smp = serial_out;
    convert_request_n_clk = 1'b0;
    #100;
    convert_request_n_clk = 1'b1;
    #100;
  endtask

  task automatic run(input int n);
    repeat (n) pulse(s);
  endtask

  task automatic recal();
    cal_reset_n = 1'b0;
    #300;
    cal_reset_n = 1'b1;
    #300;
  endtask

  // request low only while the clock stands high
  task automatic request();
    convert_request_n = 1'b0;
    #150;
    convert_request_n = 1'b1;
    #50;
  endtask

  // one serial clock period, device shifts on the fall
  task automatic sfall();
    serial_clk = 1'b1;
    #100;
    serial_clk = 1'b0;
    #200;
  endtask

  // ****************************************************************
  // one conversion with readout
  // ****************************************************************
  task automatic convert(input bit mode2, output logic [15:0] w);
    // acquisition edges first, so the start is not delayed
    run(4);
    request();
    // one unbroken burst: start, 16 bits, end
    for (int k = 0; k < 18; k++) begin
      pulse(s);
      if (k >= 2 && !mode2) w[17-k] = s;
    end
    // wait, bounded, for the ready flag
    for (int t = 0; t < 20 && done_n !== 1'b0; t++) #50;
    if (mode2) begin
      w[15] = serial_out;
      for (int i = 14; i >= 0; i--) begin
        sfall();
        w[i] = serial_out;
      end
    end
  endtask
endmodule // asrc_host_model

/* File: asrc_pkg.sv */
// constants shared by the serial readout control block
package asrc_pkg;

  // ****************************************************************
  // conversion sequence counts, in conversion clock falling edges; READ_LAST counts serial clock falls
  // ****************************************************************
  localparam int unsigned CAL_CYCLES = 14000;
  localparam int unsigned RESULT_BITS = 16;
  localparam logic [1:0] ACQ_EDGES = 2'h3;
  localparam logic [4:0] CONVERT_REQUEST_N_EDGES = 5'h10;
  localparam logic [3:0] READ_LAST = 4'hf;

  // ****************************************************************
  // range/powerdown code and reset values
  // ****************************************************************
  localparam logic [1:0] RNG_SHDN = 2'h0;
  localparam logic [1:0] RNG_UNI = 2'h1;
  localparam logic DONE_N_RST = 1'b1;

  // ****************************************************************
  // bit positions in the synchronised pin vector
  // ****************************************************************
  localparam int unsigned PIN_W = 7;
  localparam int unsigned PIN_CCLK = 0;
  localparam int unsigned PIN_SCLK = 1;
  localparam int unsigned PIN_CONVERT_REQUEST_N = 2;
  localparam int unsigned PIN_RST = 3;
  localparam int unsigned PIN_CS = 4;
  localparam int unsigned PIN_RNG0 = 5;
  localparam int unsigned PIN_RNG1 = 6;

  typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_CONVERT_REQUEST_N} asrc_state_t;

endpackage

/* File: asrc_readout_ctrl.sv */
// control, calibration and serial result readout of the converter
//
// Summary of operation
// RL1: mode 1 shifts bits on conversion clock
// RL2: reset starts 14,000-cycle calibration
// RL3: done flag falls when calibration ends
// RL4: host gives 20 clocks per conversion; the host model's convert gives 22 (4 acquisition, 18 burst)
// RL5: output changes on conversion clock fall
// RL6: burst gaps keep conversion under 20ms
// RL7: mode 2 reads out between conversions
// RL8: host syncs start request to clock
// RL9: done flag low means result ready
// RL10: next start allowed any time after readout; the code waits for the fourth edge after conversion end
// RL11: output changes on serial clock fall
// RL12: host recalibrates when clocking changes
// RL13: start waits four edges after conversion
// RL14: range pin selects range or shutdown
// RL15: sixteen bits MSB first, nothing more
`timescale 1ns/1ps
module asrc_readout_ctrl #(
  parameter int unsigned CAL_CYCLES = asrc_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic convert_request_n_clk,
  input wire logic serial_clk,
  input wire logic convert_request_n,
  input wire logic cal_reset_n,
  input wire logic chip_select_n,
  input wire logic [1:0] range_select_powerdown,
  input wire logic [15:0] sample_code,
  output logic done_n,
  output logic serial_out,
  output logic serial_out_en,
  output logic range_bipolar,
  output logic powered_down
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [asrc_pkg::PIN_W-1:0] pins, lvl, fall;
  assign pins = {range_select_powerdown, chip_select_n, cal_reset_n,
                 convert_request_n, serial_clk, convert_request_n_clk};

  asrc_sync #(.W(asrc_pkg::PIN_W)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin(pins),
    .level(lvl),
    .rise(),
    .fall(fall)
  );

  logic convert_request_n_fall, sclk_fall, rst_pin_ok, awake;
  logic [1:0] rng;
  assign convert_request_n_fall = fall[asrc_pkg::PIN_CCLK];
  assign sclk_fall = fall[asrc_pkg::PIN_SCLK];
  assign rst_pin_ok = lvl[asrc_pkg::PIN_RST];
  assign rng = {lvl[asrc_pkg::PIN_RNG1], lvl[asrc_pkg::PIN_RNG0]};
  // RL14 shutdown gates progress
  assign awake = (rng != asrc_pkg::RNG_SHDN);

  // ****************************************************************
  // sequence state
  // ****************************************************************
  localparam logic [13:0] CAL_LAST = 14'(CAL_CYCLES - 1);
  typedef asrc_pkg::asrc_state_t asrc_st_t;
  asrc_st_t state_q;
  logic [13:0] cal_cnt_q;
  logic [1:0] idle_cnt_q;
  logic [4:0] bit_cnt_q;
  logic pend_q, done_n_q;
  logic tick, start_evt, end_evt;

  // every sequence step except a pin reset happens on a conversion clock falling edge
  assign tick = convert_request_n_fall && awake && rst_pin_ok;
  // RL13 acquisition window check
  assign start_evt = tick && (state_q == asrc_pkg::ST_IDLE) && pend_q &&
                     (idle_cnt_q >= asrc_pkg::ACQ_EDGES);
  assign end_evt = tick && (state_q == asrc_pkg::ST_CONVERT_REQUEST_N) &&
                   (bit_cnt_q == asrc_pkg::CONVERT_REQUEST_N_EDGES);

  // RL8 request latched edge
  // a new request in the start cycle survives: set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (fall[asrc_pkg::PIN_CONVERT_REQUEST_N]) begin
      pend_q <= 1'b1;
    end else if (start_evt || !rst_pin_ok) begin
      pend_q <= 1'b0;
    end
  end

  // calibration, idle acquisition and conversion sequence
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= asrc_pkg::ST_CAL;
      cal_cnt_q <= '0;
      idle_cnt_q <= '0;
      bit_cnt_q <= '0;
      done_n_q <= asrc_pkg::DONE_N_RST;
    end else if (!rst_pin_ok) begin
      // RL2 pin reset recalibrates
      state_q <= asrc_pkg::ST_CAL;
      cal_cnt_q <= '0;
      done_n_q <= 1'b1;
    end else if (tick) begin
      case (state_q)
        asrc_pkg::ST_CAL: begin
          // RL3 flag at cal end
          if (cal_cnt_q == CAL_LAST) begin
            state_q <= asrc_pkg::ST_IDLE;
            done_n_q <= 1'b0;
            idle_cnt_q <= asrc_pkg::ACQ_EDGES;
          end else begin
            cal_cnt_q <= cal_cnt_q + 14'h0001;
          end
        end
        asrc_pkg::ST_IDLE: begin
          if (start_evt) begin
            state_q <= asrc_pkg::ST_CONVERT_REQUEST_N;
            done_n_q <= 1'b1;
            bit_cnt_q <= '0;
          end else if (idle_cnt_q != asrc_pkg::ACQ_EDGES) begin
            idle_cnt_q <= idle_cnt_q + 2'h1;
          end
        end
        asrc_pkg::ST_CONVERT_REQUEST_N: begin
          // RL9 result ready flag
          if (end_evt) begin
            state_q <= asrc_pkg::ST_IDLE;
            done_n_q <= 1'b0;
            idle_cnt_q <= '0;
          end else begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end
        end
        default: state_q <= asrc_pkg::ST_CAL;
      endcase
    end
  end

  // ****************************************************************
  // result shifting
  // ****************************************************************
  logic [15:0] result_q, shift_q;
  logic [3:0] rem_q;
  logic sout_q, rd_live_q;

  // one shift register serves both modes; result_q keeps the word so
  // the between-conversion readout can restart from the top
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= '0;
      shift_q <= '0;
      rem_q <= '0;
      sout_q <= 1'b0;
      rd_live_q <= 1'b0;
    end else if (start_evt) begin
      result_q <= sample_code;
      shift_q <= sample_code;
      rd_live_q <= 1'b0;
    end else if (tick && state_q == asrc_pkg::ST_CONVERT_REQUEST_N) begin
      if (end_evt) begin
        // RL7 reload for readout
        sout_q <= result_q[15];
        shift_q <= {result_q[14:0], 1'b0};
        rem_q <= asrc_pkg::READ_LAST;
        rd_live_q <= 1'b1;
      end else begin
        // RL1 bit as determined
        sout_q <= shift_q[15];
        shift_q <= {shift_q[14:0], 1'b0};
      end
    end else if (sclk_fall && state_q == asrc_pkg::ST_IDLE && awake) begin
      // RL11 serial clock fall
      if (rd_live_q && rem_q != 4'h0) begin
        sout_q <= shift_q[15];
        shift_q <= {shift_q[14:0], 1'b0};
        rem_q <= rem_q - 4'h1;
      end else begin
        // RL15 nothing past lsb
        sout_q <= 1'b0;
        rd_live_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  logic oe_q, bip_q, pd_q;
  // output drives only while selected and powered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_q <= 1'b0;
      bip_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      oe_q <= !lvl[asrc_pkg::PIN_CS] && awake;
      // RL14 range decode
      bip_q <= rng[1];
      pd_q <= !awake;
    end
  end

  assign done_n = done_n_q;
  assign serial_out = sout_q;
  assign serial_out_en = oe_q;
  assign range_bipolar = bip_q;
  assign powered_down = pd_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_CAL_HOLDS_DONE: assert property ( // RL2
    state_q == asrc_pkg::ST_CAL |-> done_n_q)
    else $error("done flag low during calibration");
  AST_CAL_END_DONE: assert property ( // RL3
    tick && state_q == asrc_pkg::ST_CAL && cal_cnt_q == CAL_LAST
    |=> !done_n_q && state_q == asrc_pkg::ST_IDLE)
    else $error("calibration end did not lower done flag");
  AST_NO_EARLY_START: assert property ( // RL13
    state_q == asrc_pkg::ST_IDLE && idle_cnt_q < asrc_pkg::ACQ_EDGES
    |=> state_q != asrc_pkg::ST_CONVERT_REQUEST_N)
    else $error("conversion began inside acquisition window");
  AST_START_NEXT_EDGE: assert property ( // RL13
    tick && state_q == asrc_pkg::ST_IDLE && pend_q && idle_cnt_q == 2'h3
    |=> state_q == asrc_pkg::ST_CONVERT_REQUEST_N && done_n_q)
    else $error("pending request not started on falling edge");
  AST_BIT_ON_CONVERT_REQUEST_N_FALL: assert property ( // RL5
    tick && state_q == asrc_pkg::ST_CONVERT_REQUEST_N && !end_evt
    |=> sout_q == $past(shift_q[15]))
    else $error("conversion bit not presented on clock fall");
  AST_DOUT_STABLE: assert property ( // RL11
    !convert_request_n_fall && !sclk_fall && !start_evt |=> $stable(sout_q))
    else $error("serial output moved without a falling edge");
  AST_READOUT_MSB: assert property ( // RL15
    end_evt |=> sout_q == $past(result_q[15]) && !done_n_q ##1 rem_q == 4'hf)
    else $error("readout did not restart at msb with flag low");
  AST_NOTHING_BEYOND: assert property ( // RL15
    sclk_fall && awake && state_q == asrc_pkg::ST_IDLE && !rd_live_q
    |=> !sout_q)
    else $error("output not zero after last bit");
  AST_SHUTDOWN_FREEZE: assert property ( // RL14
    !awake && rst_pin_ok |=> $stable(state_q) && $stable(bit_cnt_q))
    else $error("sequence advanced in shutdown");

  CV_CAL_DONE: cover property (
    state_q == asrc_pkg::ST_CAL ##1 state_q == asrc_pkg::ST_IDLE);
  CV_CONVERT_REQUEST_N_DONE: cover property (end_evt);
  CV_READOUT_END: cover property (
    sclk_fall && rd_live_q && rem_q == 4'h1);
  CV_SHUTDOWN_CONVERT_REQUEST_N: cover property (
    !awake && state_q == asrc_pkg::ST_CONVERT_REQUEST_N);

endmodule // asrc_readout_ctrl

/* File: asrc_sync.sv */
// three-flop pin synchroniser with agreed level and edge pulses
`timescale 1ns/1ps
module asrc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // ****************************************************************
  // per-bit synchroniser
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q, s2_q, s3_q, lvl_q;
      // first flop feeds only the second one
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // level moves only once stages two and three agree
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          lvl_q <= 1'b0;
        end else if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end
      assign level[i] = lvl_q;
      assign rise[i] = (s2_q == s3_q) && s3_q && !lvl_q;
      assign fall[i] = (s2_q == s3_q) && !s3_q && lvl_q;
    end
  endgenerate

endmodule // asrc_sync

/* File: tb_adc_serial_readout_control.sv */
// self-checking bench for the converter readout control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, exp, got); \
  end \
end
module tb_adc_serial_readout_control;
  localparam int unsigned CAL = 20;
  typedef struct packed {bit m2; logic [1:0] rng;
    logic [15:0] code;} asrc_row_t;
  logic clk, reset_n, chip_select_n;
  logic convert_request_n_clk, serial_clk, convert_request_n, cal_reset_n;
  logic done_n, serial_out, serial_out_en, range_bipolar, powered_down;
  logic [1:0] rng;
  logic [15:0] code;
  logic [15:0] w;
  logic dout_pin;
  // a released output shows the inverse, so a read while off is caught
  assign dout_pin = serial_out_en ? serial_out : !serial_out;
  int err_count, comparisons, cycles;
  // both readout modes, all three running range codes
  asrc_row_t rows [6] = '{'{0, 2'h1, 16'ha5c3}, '{1, 2'h2, 16'h8001},
    '{0, 2'h3, 16'hffff}, '{1, 2'h1, 16'h0000}, '{0, 2'h2, 16'h7ffe},
    '{1, 2'h3, 16'h1235}};

  asrc_readout_ctrl #(.CAL_CYCLES(CAL)) u_dut (.clk(clk), .reset_n(reset_n),
    .convert_request_n_clk(convert_request_n_clk), .serial_clk(serial_clk),
    .convert_request_n(convert_request_n), .cal_reset_n(cal_reset_n),
    .chip_select_n(chip_select_n), .range_select_powerdown(rng),
    .sample_code(code), .done_n(done_n), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .range_bipolar(range_bipolar),
    .powered_down(powered_down));

  asrc_host_model u_host (.convert_request_n_clk(convert_request_n_clk), .serial_clk(serial_clk),
    .convert_request_n(convert_request_n), .cal_reset_n(cal_reset_n),
    .done_n(done_n), .serial_out(dout_pin));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      report_and_stop();
    end
  end

  // flag must hold off until the last calibration edge
  task automatic cal_check();
    u_host.run(CAL - 1);
    `CHK("done_n", 1'b1, done_n)
    u_host.run(1);
    `CHK("done_n", 1'b0, done_n)
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    chip_select_n = 1'b1;
    rng = 2'h1;
    code = 16'h0000;
    repeat (4) @(negedge clk);
    `CHK("done_n", 1'b1, done_n)
    `CHK("serial_out_en", 1'b0, serial_out_en)
    reset_n = 1'b1;
    chip_select_n = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("serial_out_en", 1'b1, serial_out_en)
    cal_check();
    foreach (rows[i]) begin
      @(negedge clk);
      rng = rows[i].rng;
      code = rows[i].code;
      u_host.convert(rows[i].m2, w);
      `CHK("word", rows[i].code, w)
      `CHK("done_n", 1'b0, done_n)
      `CHK("range_bipolar", rows[i].rng[1], range_bipolar)
    end
    // nothing follows the sixteenth bit
    u_host.sfall();
    `CHK("serial_out", 1'b0, serial_out)
    // early request waits for the fourth edge after the end
    code = 16'hc3a5;
    u_host.request();
    repeat (3) begin
      u_host.run(1);
      `CHK("done_n", 1'b0, done_n)
    end
    u_host.run(1);
    `CHK("done_n", 1'b1, done_n)
    u_host.run(17);
    `CHK("done_n", 1'b0, done_n)
    `CHK("serial_out", 1'b1, serial_out)
    // shutdown with the clock already stopped
    @(negedge clk);
    rng = 2'h0;
    repeat (8) @(negedge clk);
    `CHK("powered_down", 1'b1, powered_down)
    `CHK("serial_out_en", 1'b0, serial_out_en)
    rng = 2'h1;
    repeat (8) @(negedge clk);
    `CHK("powered_down", 1'b0, powered_down)
    `CHK("serial_out_en", 1'b1, serial_out_en)
    // deselect releases the serial output
    chip_select_n = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("serial_out_en", 1'b0, serial_out_en)
    chip_select_n = 1'b0;
    repeat (8) @(negedge clk);
    // recalibration restarts the full count
    u_host.recal();
    `CHK("done_n", 1'b1, done_n)
    cal_check();
    report_and_stop();
  end
endmodule // tb_adc_serial_readout_control
